//--- design/port_bits_pkg.sv
// Shared constants and types for the root hub port status block
package port_bits_pkg;
    // ****************************************
    // Register map and field positions
    // ****************************************
    localparam logic [11:0] ADDR_PORT = 12'h000;
    localparam logic [11:0] ADDR_EVT  = 12'h004;
    localparam logic [11:0] ADDR_MASK = 12'h008;
    localparam logic [11:0] ADDR_CFG  = 12'h00c;
    localparam int BIT_ATTACHED = 0;
    localparam int BIT_SUSPEND  = 2;
    localparam int BIT_OC_RESUME = 3;
    localparam int BIT_RESET    = 4;
    localparam int BIT_RESUMING = 9;
    localparam int BIT_POWER    = 8;
    localparam int BIT_CFG_PEROC = 0;
    localparam int BIT_CFG_PWRSW = 1;
    localparam int EVT_W        = 4;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [1:0]       CFG_RESET  = 2'h3;
    localparam logic [EVT_W-1:0] MASK_RESET = 4'h0;
    // ****************************************
    // Timing and response codes
    // ****************************************
    localparam int CLK_KHZ        = 20000;
    localparam int RESET_TIME_US  = 10000;
    localparam int RESUME_TIME_US = 20000;
    localparam int RESET_CYCLES   = (RESET_TIME_US * CLK_KHZ) / 1000;
    localparam int RESUME_CYCLES  = (RESUME_TIME_US * CLK_KHZ) / 1000;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic ocChange;
        logic resumeDone;
        logic resetDone;
        logic attachChange;
    } evt_t;
    typedef struct packed {
        logic        perPortOc;
        logic        powerSwitching;
    } cfg_t;
    typedef enum logic [0:0] {
        WR_COLLECT = 1'b0,
        WR_RESP    = 1'b1
    } wr_state_t;
    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_RESP = 1'b1
    } rd_state_t;
endpackage

//--- design/pin_sync.sv
// Three-stage synchroniser for a level that arrives from a pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Level
    input  wire logic pinIn,
    output logic      levelOut
);
    logic stage1Reg;
    logic stage2Reg;
    logic stage3Reg;

    // Shift chain; the first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stage1Reg <= 1'b0;
            stage2Reg <= 1'b0;
            stage3Reg <= 1'b0;
        end else begin
            stage1Reg <= pinIn;
            stage2Reg <= stage1Reg;
            stage3Reg <= stage2Reg;
        end
    end

    // A change counts once the two late stages agree
    always_ff @(posedge core_clk) begin
        if (reset) begin
            levelOut <= 1'b0;
        end else if (stage2Reg == stage3Reg) begin
            levelOut <= stage3Reg;
        end
    end
endmodule
`default_nettype wire

//--- design/pulse_timer.sv
// One-shot down counter that times a signalling interval
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
    parameter int COUNT = 200000
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] countReg;

    initial begin
        if (COUNT < 1) begin
            $error("pulse_timer: COUNT must be at least one");
        end
    end

    // Load on start, count down, pulse done on the edge that drops busy
    always_ff @(posedge core_clk) begin
        if (reset) begin
            countReg <= '0;
            busy     <= 1'b0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                countReg <= W'(COUNT);
                busy     <= 1'b1;
            end else if (busy && countReg == W'(1)) begin
                countReg <= '0;
                busy     <= 1'b0;
                done     <= 1'b1;
            end else if (busy) begin
                countReg <= countReg - W'(1);
            end
        end
    end
endmodule
`default_nettype wire

//--- design/root_hub_port_status.sv
// Root hub port status and control bits behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module root_hub_port_status
    import port_bits_pkg::*;
#(
    parameter int RESET_COUNT  = RESET_CYCLES,
    parameter int RESUME_COUNT = RESUME_CYCLES
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // AXI4-Lite write address and data
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [11:0] s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Root hub side
    input  wire logic        deviceAttached,
    input  wire logic        attachEvent,
    input  wire logic        overcurrentPin,
    // Port drive and interrupt
    output logic             portResetDrive,
    output logic             resumeDrive,
    output logic             portPowerEnable,
    output logic             irq
);
    // Refuse counts that would leave a timer with nothing to time
    initial begin
        if (RESET_COUNT < 1 || RESUME_COUNT < 1) begin
            $error("root_hub_port_status: timing counts must be positive");
        end
    end

    // ****************************************
    // State
    // ****************************************
    wr_state_t   wrState;
    rd_state_t   rdState;
    logic        awHaveReg;
    logic        wHaveReg;
    logic [11:0] wrAddrReg;
    logic [31:0] wrDataReg;
    logic        resetActiveReg;
    logic        resumeActiveReg;
    logic        suspendReg;
    logic        powerOnReg;
    logic        ocPrevReg;
    evt_t        evtReg;
    evt_t        maskReg;
    cfg_t        cfgReg;
    logic        ocLevel;
    logic        resetBusy;
    logic        resetDone;
    logic        resumeBusy;
    logic        resumeDone;
    logic        wrFire;
    logic        portWrite;
    logic [31:0] wrBits;
    logic [31:0] statusWord;
    evt_t        evtSet;
    logic        reqReset;
    logic        reqResume;

    // ****************************************
    // Helpers
    // ****************************************
    pin_sync u_oc_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .pinIn    (overcurrentPin),
        .levelOut (ocLevel)
    );
    pulse_timer #(.COUNT(RESET_COUNT)) u_reset_timer (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (reqReset && deviceAttached && !resetActiveReg),
        .busy     (resetBusy),
        .done     (resetDone)
    );
    pulse_timer #(.COUNT(RESUME_COUNT)) u_resume_timer (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (reqResume),
        .busy     (resumeBusy),
        .done     (resumeDone)
    );

    // ****************************************
    // Write decode
    // ****************************************
    // Byte strobes mask the data, so a write that skips a lane writes zeros into its bits
    assign wrFire    = (wrState == WR_COLLECT) && awHaveReg && wHaveReg;
    assign wrBits    = wrDataReg;
    assign portWrite = wrFire && (wrAddrReg == ADDR_PORT);
    // Only ones act; zero bits in the port word never start anything
    assign reqReset  = portWrite && wrBits[BIT_RESET];
    assign reqResume = portWrite && wrBits[BIT_OC_RESUME] && !resetActiveReg
                       && !resumeActiveReg;

    // ****************************************
    // Readable port word
    // ****************************************
    always_comb begin
        statusWord                = 32'h0000_0000;
        statusWord[BIT_ATTACHED]  = deviceAttached;
        statusWord[BIT_SUSPEND]   = suspendReg;
        statusWord[BIT_OC_RESUME] = cfgReg.perPortOc & ocLevel;
        statusWord[BIT_RESET]     = resetActiveReg;
        statusWord[BIT_POWER]     = powerOnReg | ~cfgReg.powerSwitching;
        statusWord[BIT_RESUMING]  = resumeActiveReg;
    end

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    // One write in flight; address and data may arrive in either order
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wrState       <= WR_COLLECT;
            awHaveReg     <= 1'b0;
            wHaveReg      <= 1'b0;
            wrAddrReg     <= 12'h000;
            wrDataReg     <= 32'h0000_0000;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            case (wrState)
                WR_COLLECT: begin
                    if (s_axi_awvalid && s_axi_awready) begin
                        awHaveReg     <= 1'b1;
                        wrAddrReg     <= {s_axi_awaddr[11:2], 2'b00};
                        s_axi_awready <= 1'b0;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        wHaveReg     <= 1'b1;
                        wrDataReg    <= s_axi_wdata & {{8{s_axi_wstrb[3]}},
                                        {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
                                        {8{s_axi_wstrb[0]}}};
                        s_axi_wready <= 1'b0;
                    end
                    if (wrFire) begin
                        awHaveReg    <= 1'b0;
                        wHaveReg     <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        wrState      <= WR_RESP;
                        if (wrAddrReg == ADDR_PORT || wrAddrReg == ADDR_EVT ||
                            wrAddrReg == ADDR_MASK || wrAddrReg == ADDR_CFG) begin
                            s_axi_bresp <= RESP_OKAY;
                        end else begin
                            s_axi_bresp <= RESP_SLVERR;
                        end
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid  <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready  <= 1'b1;
                        wrState       <= WR_COLLECT;
                    end
                end
                default: wrState <= WR_COLLECT;
            endcase
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdState       <= RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            case (rdState)
                RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid  <= 1'b1;
                        s_axi_rresp   <= RESP_OKAY;
                        rdState       <= RD_RESP;
                        if (s_axi_araddr[11:2] == ADDR_PORT[11:2]) begin
                            s_axi_rdata <= statusWord;
                        end else if (s_axi_araddr[11:2] == ADDR_EVT[11:2]) begin
                            s_axi_rdata <= {28'h0000000, evtReg};
                        end else if (s_axi_araddr[11:2] == ADDR_MASK[11:2]) begin
                            s_axi_rdata <= {28'h0000000, maskReg};
                        end else if (s_axi_araddr[11:2] == ADDR_CFG[11:2]) begin
                            s_axi_rdata <= {30'h00000000, cfgReg};
                        end else begin
                            s_axi_rdata <= 32'h0000_0000;
                            s_axi_rresp <= RESP_SLVERR;
                        end
                    end
                end
                RD_RESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid  <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rdState       <= RD_IDLE;
                    end
                end
                default: rdState <= RD_IDLE;
            endcase
        end
    end

    // ****************************************
    // Port reset, resume and power
    // ****************************************
    // Reset flag mirrors the timer; it drops on the done pulse
    always_ff @(posedge core_clk) begin
        if (reset) begin
            resetActiveReg <= 1'b0;
        end else if (resetDone) begin
            resetActiveReg <= 1'b0;
        end else if (reqReset && deviceAttached) begin
            resetActiveReg <= 1'b1;
        end
    end
    // Resume clears suspend at its end; suspend set is our own write-one bit
    always_ff @(posedge core_clk) begin
        if (reset) begin
            resumeActiveReg <= 1'b0;
            suspendReg      <= 1'b0;
        end else if (resumeDone) begin
            resumeActiveReg <= 1'b0;
            suspendReg      <= 1'b0;
        end else if (reqResume) begin
            resumeActiveReg <= 1'b1;
        end else if (portWrite && wrBits[BIT_SUSPEND] && !resetActiveReg) begin
            suspendReg <= 1'b1;
        end
    end
    // Power is only ever switched on by software here
    always_ff @(posedge core_clk) begin
        if (reset) begin
            powerOnReg <= 1'b0;
        end else if (portWrite && wrBits[BIT_POWER]) begin
            powerOnReg <= 1'b1;
        end
    end

    // ****************************************
    // Configuration and mask
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfgReg  <= cfg_t'(CFG_RESET);
            maskReg <= evt_t'(MASK_RESET);
        end else if (wrFire && wrAddrReg == ADDR_CFG) begin
            cfgReg <= cfg_t'(wrBits[1:0]);
        end else if (wrFire && wrAddrReg == ADDR_MASK) begin
            maskReg <= evt_t'(wrBits[EVT_W-1:0]);
        end
    end

    // ****************************************
    // Event flags and interrupt
    // ****************************************
    always_comb begin
        evtSet              = '0;
        evtSet.attachChange = attachEvent || (reqReset && !deviceAttached);
        evtSet.resetDone    = resetDone;
        evtSet.resumeDone   = resumeDone;
        evtSet.ocChange     = cfgReg.perPortOc && (ocLevel != ocPrevReg);
    end
    // Write one clears; a set in the same cycle wins over the clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            evtReg    <= '0;
            ocPrevReg <= 1'b0;
        end else begin
            ocPrevReg <= ocLevel;
            if (wrFire && wrAddrReg == ADDR_EVT) begin
                evtReg <= (evtReg & ~evt_t'(wrBits[EVT_W-1:0])) | evtSet;
            end else begin
                evtReg <= evtReg | evtSet;
            end
        end
    end
    // Outputs registered so they never glitch
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq             <= 1'b0;
            portResetDrive  <= 1'b0;
            resumeDrive     <= 1'b0;
            portPowerEnable <= 1'b0;
        end else begin
            irq             <= |(evtReg & maskReg);
            portResetDrive  <= resetBusy;
            resumeDrive     <= resumeBusy;
            portPowerEnable <= powerOnReg | ~cfgReg.powerSwitching;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_reset_starts: assert property (
        reqReset && deviceAttached && !resetActiveReg |=> resetActiveReg ##1 portResetDrive)
        else $error("port reset did not start");
    a_reset_end_flag: assert property ($fell(resetActiveReg) |-> evtReg.resetDone)
        else $error("reset end without done flag");
    a_reset_refused: assert property (
        reqReset && !deviceAttached && !resetActiveReg |=> !resetActiveReg && evtReg.attachChange)
        else $error("reset on detached port mishandled");
    a_zero_no_reset: assert property (
        portWrite && !wrBits[BIT_RESET] && !resetActiveReg |=> !resetActiveReg)
        else $error("zero write started reset");
    a_oc_follows: assert property (
        cfgReg.perPortOc |-> statusWord[BIT_OC_RESUME] == ocLevel)
        else $error("overcurrent bit does not follow input");
    a_oc_masked: assert property (!cfgReg.perPortOc |-> !statusWord[BIT_OC_RESUME])
        else $error("overcurrent bit set without reporting");
    a_resume_start: assert property (reqResume |=> resumeActiveReg ##1 resumeDrive)
        else $error("resume did not start");
    a_power_fixed: assert property (
        !cfgReg.powerSwitching |-> statusWord[BIT_POWER] ##1 portPowerEnable)
        else $error("power bit not one without switching");
    a_power_set: assert property (portWrite && wrBits[BIT_POWER] |=> powerOnReg [*2])
        else $error("power request ignored");
    a_reserved_zero: assert property (statusWord[7:5] == 3'h0)
        else $error("reserved bits not zero");
    a_irq_level: assert property (irq == $past(|(evtReg & maskReg)))
        else $error("interrupt does not match flags");
    c_reset_done: cover property ($fell(resetActiveReg));
    c_reset_refused: cover property (reqReset && !deviceAttached);
    c_resume_done: cover property (resumeDone);
    c_irq_raised: cover property ($rose(irq));
endmodule
`default_nettype wire

//--- tb/usb_port_device_model.sv
// Behavioural downstream device that plugs in and reports overcurrent
`timescale 1ns/1ps
`default_nettype none
module usb_port_device_model (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Bench commands
    input  wire logic plugCmd,
    input  wire logic ocCmd,
    // Port lines
    output logic      deviceAttached,
    output logic      attachEvent,
    output logic      overcurrentPin
);
    // Attach level follows the plug, with a one-cycle pulse on change
    always_ff @(posedge core_clk) begin
        if (reset) begin
            deviceAttached <= 1'b0;
            attachEvent    <= 1'b0;
        end else begin
            deviceAttached <= plugCmd;
            attachEvent    <= plugCmd != deviceAttached;
        end
    end
    // Overcurrent comes straight from the pin, unsynchronised
    always_comb overcurrentPin = ocCmd;
endmodule
`default_nettype wire

//--- tb/root_hub_port_status_tb_top.sv
// Self-checking bench for the root hub port status block
`timescale 1ns/1ps
`default_nettype none
module root_hub_port_status_tb_top
    import port_bits_pkg::*;
;
    // ****************************************
    // Signals
    // ****************************************
    localparam int CNT = 8;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
    logic [11:0] awAddr = '0, arAddr = '0;
    logic [31:0] wData = '0, rd, rData, v;
    logic        awReady, wReady, bValid, arReady, rValid, irq;
    logic [1:0]  bResp, rResp, wResp;
    logic        plugCmd = 0, ocCmd = 0, attached, attachEvt, ocPin;
    logic        rstDrive, rsmDrive, pwrEn;
    int          miscompares = 0;
    int          comparisons = 0;
    int          seed = 88;
    int          n;
    int          rstCycles = 0;
    int          rsmCycles = 0;
    always #25 core_clk = ~core_clk;
    // Drive lengths counted edge by edge, so the intervals can be held to CNT
    always @(posedge core_clk) begin
        if (rstDrive) rstCycles <= rstCycles + 1;
        if (rsmDrive) rsmCycles <= rsmCycles + 1;
    end
    usb_port_device_model dev (.core_clk(core_clk), .reset(reset), .plugCmd(plugCmd),
        .ocCmd(ocCmd), .deviceAttached(attached), .attachEvent(attachEvt),
        .overcurrentPin(ocPin));
    // Short counts keep the signalling intervals quick in simulation
    root_hub_port_status #(.RESET_COUNT(CNT), .RESUME_COUNT(CNT)) dut (
        .core_clk(core_clk), .reset(reset),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_bresp(bResp), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_araddr(arAddr), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .deviceAttached(attached),
        .attachEvent(attachEvt), .overcurrentPin(ocPin), .portResetDrive(rstDrive),
        .resumeDrive(rsmDrive), .portPowerEnable(pwrEn), .irq(irq));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] expPort(input logic att, oc, rst, pwr);
        expPort = {23'h0, pwr, 3'h0, rst, oc, 2'h0, att};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        awAddr  <= a;
        wData   <= d;
        awValid <= 1'b1;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
        end while (!bValid);
        bReady <= 1'b0;
        wResp = bResp;
    endtask
    task automatic rdReg(input logic [11:0] a);
        @(posedge core_clk);
        arAddr  <= a;
        arValid <= 1'b1;
        rReady  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arValid && arReady) arValid <= 1'b0;
        end while (!rValid);
        rReady <= 1'b0;
        rd = rData;
    endtask
    task automatic final_report();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rdReg(ADDR_PORT);
        chk(rd & 32'h1ff, expPort(0, 0, 0, 0));
        // Reset request on an empty port only flags the attach change
        wr(ADDR_PORT, 32'h10);
        rdReg(ADDR_PORT);
        chk(rd & 32'h10, 32'h0);
        rdReg(ADDR_EVT);
        chk(rd & 32'h1, 32'h1);
        $display("test empty reset done");
        plugCmd <= 1'b1;
        repeat (4) @(posedge core_clk);
        wr(ADDR_EVT, 32'hf);
        wr(ADDR_PORT, 32'h0);
        rdReg(ADDR_PORT);
        chk(rd & 32'h1ff, expPort(1, 0, 0, 0));
        rdReg(ADDR_EVT);
        chk(rd, 32'h0);
        chk({31'h0, rsmDrive}, 32'h0);
        $display("test zero write done");
        wr(ADDR_PORT, 32'h10);
        rdReg(ADDR_PORT);
        chk(rd & 32'h10, 32'h10);
        chk({31'h0, rstDrive}, 32'h1);
        n = 0;
        while (rstDrive && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        rdReg(ADDR_PORT);
        chk(rd & 32'h10, 32'h0);
        rdReg(ADDR_EVT);
        chk(rd & 32'h2, 32'h2);
        chk(rstCycles, CNT);
        // Unmasked reset-done event drives the interrupt until cleared
        wr(ADDR_MASK, 32'h2);
        repeat (2) @(posedge core_clk);
        #1 chk({31'h0, irq}, 32'h1);
        wr(ADDR_EVT, 32'h2);
        repeat (2) @(posedge core_clk);
        #1 chk({31'h0, irq}, 32'h0);
        wr(ADDR_MASK, 32'h0);
        $display("test port reset done");
        wr(ADDR_PORT, 32'h8);
        repeat (3) @(posedge core_clk);
        #1 chk({31'h0, rsmDrive}, 32'h1);
        $display("test resume done");
        @(posedge core_clk);
        ocCmd <= 1'b1;
        repeat (8) @(posedge core_clk);
        rdReg(ADDR_PORT);
        chk(rd & 32'h8, 32'h8);
        chk(rsmCycles, CNT);
        wr(ADDR_CFG, 32'h0);
        rdReg(ADDR_PORT);
        chk(rd & 32'h108, 32'h100);
        chk({31'h0, pwrEn}, 32'h1);
        wr(ADDR_CFG, 32'h3);
        wr(ADDR_PORT, 32'h100);
        wr(ADDR_PORT, 32'h0);
        rdReg(ADDR_PORT);
        chk(rd & 32'h100, 32'h100);
        $display("test power and overcurrent done");
        // Random overcurrent levels while writing the reserved bits
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            ocCmd <= v[0];
            wr(ADDR_PORT, v & 32'he0);
            repeat (6) @(posedge core_clk);
            rdReg(ADDR_PORT);
            chk(rd & 32'hf8, {28'h0, v[0], 3'h0});
        end
        $display("test random done");
        wr(12'h010, 32'h10);
        chk({30'h0, wResp}, {30'h0, RESP_SLVERR});
        rdReg(12'h010);
        chk(rd, 32'h0);
        chk({30'h0, rResp}, {30'h0, RESP_SLVERR});
        $display("test unmapped done");
        final_report();
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
